// File: design/cabe_consts.vh
// Constants for the core execution unit: opcodes, flag positions, cycle counts
`ifndef CABE_CONSTS_VH
`define CABE_CONSTS_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CABE_OP_W 6
`define CABE_PC_W 16
`define CABE_OFS_W 12

// ----------------------------------------
// Operation codes from the decode stage
// ----------------------------------------
`define CABE_OP_ADD 6'h00
`define CABE_OP_ADD_CARRY 6'h01
`define CABE_OP_WORD_IMMEDIATE_ADD 6'h02
`define CABE_OP_SUB 6'h03
`define CABE_OP_SUB_CONST 6'h04
`define CABE_OP_SUB_CARRY 6'h05
`define CABE_OP_SUB_CARRY_CONST 6'h06
`define CABE_OP_WORD_IMMEDIATE_SUBTRACT 6'h07
`define CABE_OP_AND 6'h08
`define CABE_OP_AND_CONST 6'h09
`define CABE_OP_OR 6'h0A
`define CABE_OP_OR_CONST 6'h0B
`define CABE_OP_XOR 6'h0C
`define CABE_OP_ONES_COMP 6'h0D
`define CABE_OP_TWOS_COMP 6'h0E
`define CABE_OP_MASK_SET_BITS 6'h0F
`define CABE_OP_MASK_CLEAR_BITS 6'h10
`define CABE_OP_INC 6'h11
`define CABE_OP_DEC 6'h12
`define CABE_OP_TEST 6'h13
`define CABE_OP_CLEAR_REG 6'h14
`define CABE_OP_SET_REG 6'h15
`define CABE_OP_RELATIVE_JUMP 6'h16
`define CABE_OP_POINTER_JUMP 6'h17
`define CABE_OP_RELATIVE_CALL 6'h18
`define CABE_OP_POINTER_CALL 6'h19
`define CABE_OP_COMPARE_SKIP_EQUAL 6'h1A
`define CABE_OP_COMPARE 6'h1B
`define CABE_OP_COMPARE_CARRY 6'h1C
`define CABE_OP_COMPARE_CONST 6'h1D
`define CABE_OP_SKIP_REG_BIT_CLEAR 6'h1E
`define CABE_OP_SKIP_REG_BIT_SET 6'h1F
`define CABE_OP_SKIP_IO_BIT_CLEAR 6'h20
`define CABE_OP_SKIP_IO_BIT_SET 6'h21
`define CABE_OP_BRANCH_FLAG_SET 6'h22
`define CABE_OP_BRANCH_FLAG_CLEAR 6'h23

// ----------------------------------------
// Status flag bit positions
// ----------------------------------------
`define CABE_FLAG_C 0
`define CABE_FLAG_Z 1
`define CABE_FLAG_N 2
`define CABE_FLAG_V 3
`define CABE_FLAG_S 4
`define CABE_FLAG_H 5

// ----------------------------------------
// Data constants and cycle counts
// ----------------------------------------
`define CABE_ALL_ONES 8'hFF
`define CABE_ALL_ZERO 8'h00
`define CABE_MIN_NEG 8'h80
`define CABE_MAX_POS 8'h7F
`define CABE_CYC_ONE 2'h1
`define CABE_CYC_TWO 2'h2
`define CABE_CYC_THREE 2'h3
`define CABE_PC_STEP_ONE 16'h0001
`define CABE_PC_SKIP_ONE 16'h0002
`define CABE_PC_SKIP_TWO 16'h0003

`endif

// File: design/cabe_exec.v
// Arithmetic, logic, flow-change and skip execution unit of the core
`timescale 1ns/1ps
`default_nettype none
`include "cabe_consts.vh"

// Notes on behaviour
// - Add registers, optional carry, ZCNVH, one cycle
// - Word add/subtract immediate, ZCNVS, two cycles
// - Subtract register/constant, optional carry, ZCNVH
// - AND/OR/XOR set ZNV only, carry kept
// - Ones complement ZCNV; twos complement adds H
// - Set bits ORs mask, flags ZNV
// - Clear bits ANDs with 0xFF minus mask
// - Increment/decrement one cycle, ZNV, carry kept
// - Test ANDs with itself, register unchanged
// - Clear gives zero ZNV; set-register flagless
// - Relative jump to PC+k+1, two cycles
// - Pointer jump loads PC from Z, two cycles
// - Relative call saves return, three cycles
// - Pointer call to Z saves return, three
// - Compares set flags only, no write
// - Compare-skip on equal, 1/2/3 cycles
// - Skip on register bit value, 1/2/3
// - Skip on I/O bit value, 1/2/3
// - Flag branch to PC+k+1, 1 or 2
module cabe_exec (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_start,
  input wire [`CABE_OP_W-1:0] i_op,
  input wire [7:0] i_rd,
  input wire [7:0] i_rd_high,
  input wire [7:0] i_rr,
  input wire [7:0] i_imm,
  input wire [2:0] i_bit_sel,
  input wire [7:0] i_io_reg,
  input wire [7:0] i_sreg,
  input wire [`CABE_PC_W-1:0] i_pc,
  input wire [`CABE_PC_W-1:0] i_z_ptr,
  input wire [`CABE_OFS_W-1:0] i_offset,
  input wire i_next_two_word,
  output reg [7:0] o_result_q,
  output reg [7:0] o_result_high_q,
  output reg o_result_we_q,
  output reg o_word_we_q,
  output reg [7:0] o_sreg_q,
  output reg o_sreg_we_q,
  output reg [`CABE_PC_W-1:0] o_pc_q,
  output reg o_pc_we_q,
  output reg [`CABE_PC_W-1:0] o_return_addr_q,
  output reg o_push_q,
  output reg o_busy_q,
  output reg o_done_q
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------

  // Operations that take the immediate instead of the second register
  function uses_const;
    input [`CABE_OP_W-1:0] op;
    begin
      uses_const = (op == `CABE_OP_SUB_CONST) || (op == `CABE_OP_SUB_CARRY_CONST) ||
                   (op == `CABE_OP_AND_CONST) || (op == `CABE_OP_OR_CONST) ||
                   (op == `CABE_OP_MASK_SET_BITS) || (op == `CABE_OP_MASK_CLEAR_BITS) ||
                   (op == `CABE_OP_COMPARE_CONST);
    end
  endfunction

  // Operations that fold in the incoming carry
  function uses_carry;
    input [`CABE_OP_W-1:0] op;
    begin
      uses_carry = (op == `CABE_OP_ADD_CARRY) || (op == `CABE_OP_SUB_CARRY) ||
                   (op == `CABE_OP_SUB_CARRY_CONST) || (op == `CABE_OP_COMPARE_CARRY);
    end
  endfunction

  // Half carry, overflow and carry of an 8-bit addition, as {h, v, c}
  function [2:0] add_flags;
    input [7:0] a;
    input [7:0] b;
    input [7:0] r;
    begin
      add_flags[2] = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
      add_flags[1] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      add_flags[0] = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
    end
  endfunction

  // Half borrow, overflow and borrow of an 8-bit subtraction, as {h, v, c}
  function [2:0] sub_flags;
    input [7:0] a;
    input [7:0] b;
    input [7:0] r;
    begin
      sub_flags[2] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      sub_flags[1] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      sub_flags[0] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0] cnt_q;
  wire [1:0] cnt_d;
  reg [4:0] pend_q;

  reg [7:0] res_d;
  reg [7:0] res_high_d;
  reg [7:0] sreg_d;
  reg [`CABE_PC_W-1:0] pc_d;
  reg wr_d, word_d, sreg_wr_d, pc_wr_d, push_d;
  reg [1:0] cyc_d;

  reg [7:0] opb;
  reg cin;
  reg [7:0] sum;
  reg [7:0] dif;
  reg [15:0] wsum;
  reg [15:0] wdif;
  reg [2:0] hvc;
  reg skip;
  reg [`CABE_PC_W-1:0] rel_pc;
  reg [`CABE_PC_W-1:0] skip_pc;

  // ----------------------------------------
  // Execution datapath
  // ----------------------------------------

  // Computes result, new flags, new PC and the cycle cost of one operation
  always @*
  begin
    opb = uses_const(i_op) ? i_imm : i_rr;
    cin = uses_carry(i_op) ? i_sreg[`CABE_FLAG_C] : 1'b0;
    sum = i_rd + opb + {7'h00, cin};
    dif = i_rd - opb - {7'h00, cin};
    wsum = {i_rd_high, i_rd} + {8'h00, i_imm};
    wdif = {i_rd_high, i_rd} - {8'h00, i_imm};
    rel_pc = i_pc + {{4{i_offset[`CABE_OFS_W-1]}}, i_offset} + `CABE_PC_STEP_ONE;
    skip_pc = i_pc + (i_next_two_word ? `CABE_PC_SKIP_TWO : `CABE_PC_SKIP_ONE);
    hvc = 3'h0;
    skip = 1'b0;
    res_d = i_rd;
    res_high_d = i_rd_high;
    sreg_d = i_sreg;
    pc_d = i_pc;
    wr_d = 1'b0;
    word_d = 1'b0;
    sreg_wr_d = 1'b0;
    pc_wr_d = 1'b0;
    push_d = 1'b0;
    cyc_d = `CABE_CYC_ONE;
    case (i_op)
      `CABE_OP_ADD, `CABE_OP_ADD_CARRY:
      begin
        res_d = sum;
        hvc = add_flags(i_rd, opb, sum);
        wr_d = 1'b1;
        sreg_wr_d = 1'b1;
        sreg_d[`CABE_FLAG_H] = hvc[2];
        sreg_d[`CABE_FLAG_V] = hvc[1];
        sreg_d[`CABE_FLAG_C] = hvc[0];
        sreg_d[`CABE_FLAG_N] = sum[7];
        sreg_d[`CABE_FLAG_Z] = (sum == `CABE_ALL_ZERO);
      end
      `CABE_OP_SUB, `CABE_OP_SUB_CONST, `CABE_OP_SUB_CARRY, `CABE_OP_SUB_CARRY_CONST,
      `CABE_OP_COMPARE, `CABE_OP_COMPARE_CARRY, `CABE_OP_COMPARE_CONST:
      begin
        res_d = dif;
        hvc = sub_flags(i_rd, opb, dif);
        // Compares only update flags
        wr_d = (i_op != `CABE_OP_COMPARE) && (i_op != `CABE_OP_COMPARE_CARRY) &&
               (i_op != `CABE_OP_COMPARE_CONST);
        sreg_wr_d = 1'b1;
        sreg_d[`CABE_FLAG_H] = hvc[2];
        sreg_d[`CABE_FLAG_V] = hvc[1];
        sreg_d[`CABE_FLAG_C] = hvc[0];
        sreg_d[`CABE_FLAG_N] = dif[7];
        // Carry forms keep zero only if the earlier bytes were zero too
        sreg_d[`CABE_FLAG_Z] = (dif == `CABE_ALL_ZERO) &
                               (~uses_carry(i_op) | i_sreg[`CABE_FLAG_Z]);
      end
      `CABE_OP_WORD_IMMEDIATE_ADD, `CABE_OP_WORD_IMMEDIATE_SUBTRACT:
      begin
        // Pair is treated as one 16-bit word
        if (i_op == `CABE_OP_WORD_IMMEDIATE_ADD)
        begin
          {res_high_d, res_d} = wsum;
          sreg_d[`CABE_FLAG_V] = ~i_rd_high[7] & wsum[15];
          sreg_d[`CABE_FLAG_C] = ~wsum[15] & i_rd_high[7];
        end
        else
        begin
          {res_high_d, res_d} = wdif;
          sreg_d[`CABE_FLAG_V] = i_rd_high[7] & ~wdif[15];
          sreg_d[`CABE_FLAG_C] = wdif[15] & ~i_rd_high[7];
        end
        sreg_d[`CABE_FLAG_N] = res_high_d[7];
        sreg_d[`CABE_FLAG_Z] = ({res_high_d, res_d} == 16'h0000);
        sreg_d[`CABE_FLAG_S] = sreg_d[`CABE_FLAG_N] ^ sreg_d[`CABE_FLAG_V];
        wr_d = 1'b1;
        word_d = 1'b1;
        sreg_wr_d = 1'b1;
        cyc_d = `CABE_CYC_TWO;
      end
      `CABE_OP_AND, `CABE_OP_AND_CONST, `CABE_OP_OR, `CABE_OP_OR_CONST, `CABE_OP_XOR,
      `CABE_OP_MASK_SET_BITS, `CABE_OP_MASK_CLEAR_BITS, `CABE_OP_TEST, `CABE_OP_CLEAR_REG:
      begin
        case (i_op)
          `CABE_OP_AND, `CABE_OP_AND_CONST: res_d = i_rd & opb;
          `CABE_OP_OR, `CABE_OP_OR_CONST: res_d = i_rd | opb;
          `CABE_OP_XOR: res_d = i_rd ^ opb;
          `CABE_OP_MASK_SET_BITS: res_d = i_rd | opb;
          `CABE_OP_MASK_CLEAR_BITS: res_d = i_rd & (`CABE_ALL_ONES - opb);
          `CABE_OP_CLEAR_REG: res_d = i_rd ^ i_rd;
          default: res_d = i_rd & i_rd;
        endcase
        // Test leaves the register as it was
        wr_d = (i_op != `CABE_OP_TEST);
        sreg_wr_d = 1'b1;
        sreg_d[`CABE_FLAG_V] = 1'b0;
        sreg_d[`CABE_FLAG_N] = res_d[7];
        sreg_d[`CABE_FLAG_Z] = (res_d == `CABE_ALL_ZERO);
      end
      `CABE_OP_ONES_COMP:
      begin
        res_d = `CABE_ALL_ONES - i_rd;
        wr_d = 1'b1;
        sreg_wr_d = 1'b1;
        sreg_d[`CABE_FLAG_C] = 1'b1;
        sreg_d[`CABE_FLAG_V] = 1'b0;
        sreg_d[`CABE_FLAG_N] = res_d[7];
        sreg_d[`CABE_FLAG_Z] = (res_d == `CABE_ALL_ZERO);
      end
      `CABE_OP_TWOS_COMP:
      begin
        res_d = `CABE_ALL_ZERO - i_rd;
        wr_d = 1'b1;
        sreg_wr_d = 1'b1;
        sreg_d[`CABE_FLAG_H] = res_d[3] | i_rd[3];
        sreg_d[`CABE_FLAG_C] = (res_d != `CABE_ALL_ZERO);
        sreg_d[`CABE_FLAG_V] = (res_d == `CABE_MIN_NEG);
        sreg_d[`CABE_FLAG_N] = res_d[7];
        sreg_d[`CABE_FLAG_Z] = (res_d == `CABE_ALL_ZERO);
      end
      `CABE_OP_INC, `CABE_OP_DEC:
      begin
        // Carry is left alone so multi-byte loops can chain it
        res_d = (i_op == `CABE_OP_INC) ? i_rd + 8'h01 : i_rd - 8'h01;
        wr_d = 1'b1;
        sreg_wr_d = 1'b1;
        sreg_d[`CABE_FLAG_V] = (i_op == `CABE_OP_INC) ? (res_d == `CABE_MIN_NEG) :
                               (res_d == `CABE_MAX_POS);
        sreg_d[`CABE_FLAG_N] = res_d[7];
        sreg_d[`CABE_FLAG_Z] = (res_d == `CABE_ALL_ZERO);
      end
      `CABE_OP_SET_REG:
      begin
        res_d = `CABE_ALL_ONES;
        wr_d = 1'b1;
      end
      `CABE_OP_RELATIVE_JUMP, `CABE_OP_RELATIVE_CALL:
      begin
        pc_d = rel_pc;
        pc_wr_d = 1'b1;
        push_d = (i_op == `CABE_OP_RELATIVE_CALL);
        cyc_d = push_d ? `CABE_CYC_THREE : `CABE_CYC_TWO;
      end
      `CABE_OP_POINTER_JUMP, `CABE_OP_POINTER_CALL:
      begin
        pc_d = i_z_ptr;
        pc_wr_d = 1'b1;
        push_d = (i_op == `CABE_OP_POINTER_CALL);
        cyc_d = push_d ? `CABE_CYC_THREE : `CABE_CYC_TWO;
      end
      `CABE_OP_COMPARE_SKIP_EQUAL, `CABE_OP_SKIP_REG_BIT_CLEAR, `CABE_OP_SKIP_REG_BIT_SET,
      `CABE_OP_SKIP_IO_BIT_CLEAR, `CABE_OP_SKIP_IO_BIT_SET:
      begin
        case (i_op)
          `CABE_OP_COMPARE_SKIP_EQUAL: skip = (i_rd == i_rr);
          `CABE_OP_SKIP_REG_BIT_CLEAR: skip = ~i_rr[i_bit_sel];
          `CABE_OP_SKIP_REG_BIT_SET: skip = i_rr[i_bit_sel];
          `CABE_OP_SKIP_IO_BIT_CLEAR: skip = ~i_io_reg[i_bit_sel];
          default: skip = i_io_reg[i_bit_sel];
        endcase
        pc_d = skip_pc;
        pc_wr_d = skip;
        cyc_d = skip ? (i_next_two_word ? `CABE_CYC_THREE : `CABE_CYC_TWO) : `CABE_CYC_ONE;
      end
      `CABE_OP_BRANCH_FLAG_SET, `CABE_OP_BRANCH_FLAG_CLEAR:
      begin
        skip = (i_op == `CABE_OP_BRANCH_FLAG_SET) ? i_sreg[i_bit_sel] : ~i_sreg[i_bit_sel];
        pc_d = rel_pc;
        pc_wr_d = skip;
        cyc_d = skip ? `CABE_CYC_TWO : `CABE_CYC_ONE;
      end
      default: cyc_d = `CABE_CYC_ONE; // Unknown codes finish with no strobes
    endcase
  end

  // ----------------------------------------
  // Cycle sequencing
  // ----------------------------------------

  // Remaining-cycle count: loads only when idle, runs down to the finishing edge
  assign cnt_d = (cnt_q != 2'h0) ? (cnt_q - 2'h1) : (i_start ? (cyc_d - 2'h1) : 2'h0);

  // Latches the outcome at acceptance; strobes write enables on the last cycle
  always @(posedge i_clock)
  begin
    if (!i_reset_n)
    begin
      cnt_q <= 2'h0;
      pend_q <= 5'h00;
      o_result_q <= 8'h00;
      o_result_high_q <= 8'h00;
      o_sreg_q <= 8'h00;
      o_pc_q <= 16'h0000;
      o_return_addr_q <= 16'h0000;
      o_result_we_q <= 1'b0;
      o_word_we_q <= 1'b0;
      o_sreg_we_q <= 1'b0;
      o_pc_we_q <= 1'b0;
      o_push_q <= 1'b0;
      o_busy_q <= 1'b0;
      o_done_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      o_busy_q <= (cnt_d != 2'h0);
      // Strobes last exactly one cycle unless raised again below
      {o_push_q, o_pc_we_q, o_sreg_we_q, o_word_we_q, o_result_we_q} <= 5'h00;
      o_done_q <= 1'b0;
      if (cnt_q == 2'h1)
      begin
        // Final cycle of a multi-cycle operation
        {o_push_q, o_pc_we_q, o_sreg_we_q, o_word_we_q, o_result_we_q} <= pend_q;
        o_done_q <= 1'b1;
      end
      else if ((cnt_q == 2'h0) && i_start)
      begin
        o_result_q <= res_d;
        o_result_high_q <= res_high_d;
        o_sreg_q <= sreg_d;
        o_pc_q <= pc_d;
        o_return_addr_q <= i_pc + `CABE_PC_STEP_ONE;
        pend_q <= {push_d, pc_wr_d, sreg_wr_d, word_d, wr_d};
        if (cyc_d == `CABE_CYC_ONE)
        begin
          {o_push_q, o_pc_we_q, o_sreg_we_q, o_word_we_q, o_result_we_q} <=
            {push_d, pc_wr_d, sreg_wr_d, word_d, wr_d};
          o_done_q <= 1'b1;
        end
      end
    end
  end

endmodule // cabe_exec
`default_nettype wire

// File: testbench/cabe_exec_assertions.sv
// Concurrent checks on the execution unit ports
`timescale 1ns/1ps
`default_nettype none
`include "cabe_consts.vh"
module cabe_exec_assertions (
  input wire i_clock,
  input wire i_reset_n,
  input wire i_start,
  input wire [`CABE_OP_W-1:0] i_op,
  input wire [7:0] i_rd,
  input wire [7:0] i_rr,
  input wire [7:0] i_sreg,
  input wire [`CABE_PC_W-1:0] i_pc,
  input wire [`CABE_PC_W-1:0] i_z_ptr,
  input wire [7:0] o_result_q,
  input wire o_result_we_q,
  input wire o_word_we_q,
  input wire [7:0] o_sreg_q,
  input wire o_sreg_we_q,
  input wire [`CABE_PC_W-1:0] o_pc_q,
  input wire o_pc_we_q,
  input wire [`CABE_PC_W-1:0] o_return_addr_q,
  input wire o_push_q,
  input wire o_busy_q,
  input wire o_done_q
);
  // ----------------------------------------
  // Acceptance and step sequences
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Operation accepted at this edge
  wire take = i_start && !o_busy_q;
  wire carry_in = i_sreg[`CABE_FLAG_C];
  sequence s_two;
    o_busy_q && !o_done_q ##1 o_done_q && !o_busy_q;
  endsequence
  sequence s_three;
    o_busy_q[*2] ##1 o_done_q && !o_busy_q;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_add_one_cycle: assert property (take && i_op == `CABE_OP_ADD |=>
    o_done_q && o_result_we_q && o_sreg_we_q) else $error("add not done in one cycle");
  a_word_two_cycles: assert property (take && i_op == `CABE_OP_WORD_IMMEDIATE_ADD |=>
    s_two ##0 o_word_we_q && o_result_we_q) else $error("word add timing wrong");
  a_logic_keeps_carry: assert property (take && i_op == `CABE_OP_AND |=>
    o_sreg_q[`CABE_FLAG_C] == $past(carry_in)) else $error("logic op changed carry");
  a_set_reg_flagless: assert property (take && i_op == `CABE_OP_SET_REG |=>
    o_result_q == 8'hFF && o_result_we_q && !o_sreg_we_q) else $error("set register wrong");
  a_jump_two_cycles: assert property (take && i_op == `CABE_OP_RELATIVE_JUMP |=>
    s_two ##0 o_pc_we_q && !o_sreg_we_q) else $error("relative jump timing wrong");
  a_pointer_jump_target: assert property (take && i_op == `CABE_OP_POINTER_JUMP |=>
    o_pc_q == $past(i_z_ptr) ##1 o_done_q && o_pc_we_q) else $error("pointer jump wrong");
  a_call_three_cycles: assert property (take && i_op == `CABE_OP_RELATIVE_CALL |=>
    o_return_addr_q == $past(i_pc) + 16'h0001 ##0 s_three ##0 o_push_q)
    else $error("relative call wrong");
  a_pointer_call_push: assert property (take && i_op == `CABE_OP_POINTER_CALL |=>
    s_three ##0 o_push_q && o_pc_we_q) else $error("pointer call wrong");
  a_compare_no_write: assert property (take && i_op == `CABE_OP_COMPARE |=>
    o_done_q && o_sreg_we_q && !o_result_we_q) else $error("compare wrote register");
  a_unequal_no_skip: assert property (take && i_op == `CABE_OP_COMPARE_SKIP_EQUAL &&
    i_rd != i_rr |=> o_done_q && !o_pc_we_q) else $error("unequal compare skipped");
endmodule // cabe_exec_assertions
bind cabe_exec cabe_exec_assertions u_chk (.i_clock, .i_reset_n, .i_start, .i_op, .i_rd,
  .i_rr, .i_sreg, .i_pc, .i_z_ptr, .o_result_q, .o_result_we_q, .o_word_we_q, .o_sreg_q,
  .o_sreg_we_q, .o_pc_q, .o_pc_we_q, .o_return_addr_q, .o_push_q, .o_busy_q, .o_done_q);
`default_nettype wire

// File: testbench/cpu_alu_branch_exec_bench.sv
// Self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "cabe_consts.vh"
module cpu_alu_branch_exec_bench;
  logic i_clock, i_reset_n, i_start, i_next_two_word;
  logic [5:0] i_op;
  logic [7:0] i_rd, i_rd_high, i_rr, i_imm, i_io_reg, i_sreg;
  logic [2:0] i_bit_sel;
  logic [15:0] i_pc, i_z_ptr;
  logic [11:0] i_offset;
  wire [7:0] o_result_q, o_result_high_q, o_sreg_q;
  wire o_result_we_q, o_word_we_q, o_sreg_we_q, o_pc_we_q, o_push_q, o_busy_q, o_done_q;
  wire [15:0] o_pc_q, o_return_addr_q;
  int fail_count, n_tests, cycles;
  cabe_exec dut (.i_clock, .i_reset_n, .i_start, .i_op, .i_rd, .i_rd_high, .i_rr, .i_imm,
    .i_bit_sel, .i_io_reg, .i_sreg, .i_pc, .i_z_ptr, .i_offset, .i_next_two_word,
    .o_result_q, .o_result_high_q, .o_result_we_q, .o_word_we_q, .o_sreg_q, .o_sreg_we_q,
    .o_pc_q, .o_pc_we_q, .o_return_addr_q, .o_push_q, .o_busy_q, .o_done_q);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task opnd(input logic [7:0] rd, input logic [7:0] rr, input logic [7:0] k,
    input logic [7:0] sr);
    i_rd = rd;
    i_rr = rr;
    i_imm = k;
    i_sreg = sr;
  endtask
  // Issue one operation and count cycles until done
  task go(input logic [5:0] op, input logic [3:0] n);
    logic [3:0] c;
    @(negedge i_clock);
    i_op = op;
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    c = 4'h1;
    while (o_done_q !== 1'b1 && c < 4'h8)
    begin
      @(negedge i_clock);
      c++;
    end
    chk({12'h000, c}, {12'h000, n});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_arith;
    opnd(8'h0F, 8'h01, 8'h00, 8'h00);
    go(`CABE_OP_ADD, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h1020);
    opnd(8'hFF, 8'h00, 8'h00, 8'h01);
    go(`CABE_OP_ADD_CARRY, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h0023);
    opnd(8'h80, 8'h01, 8'h00, 8'h00);
    go(`CABE_OP_SUB, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h7F28);
    opnd(8'h10, 8'h00, 8'h01, 8'h00);
    go(`CABE_OP_SUB_CONST, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h0F20);
    opnd(8'h10, 8'h0F, 8'h00, 8'h03);
    go(`CABE_OP_SUB_CARRY, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h0022);
    opnd(8'h20, 8'h00, 8'h10, 8'h01);
    go(`CABE_OP_SUB_CARRY_CONST, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h0F20);
    opnd(8'h00, 8'h00, 8'h00, 8'h00);
    go(`CABE_OP_ONES_COMP, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'hFF05);
    opnd(8'h80, 8'h00, 8'h00, 8'h00);
    go(`CABE_OP_TWOS_COMP, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h800D);
    $display("arithmetic test done");
  endtask
  task t_logic;
    opnd(8'hF0, 8'h0F, 8'h00, 8'h01);
    go(`CABE_OP_AND, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h0003);
    opnd(8'h80, 8'h00, 8'h01, 8'h09);
    go(`CABE_OP_OR_CONST, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h8105);
    opnd(8'hFF, 8'h0F, 8'h00, 8'h01);
    go(`CABE_OP_XOR, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'hF005);
    opnd(8'h10, 8'h00, 8'h01, 8'h01);
    go(`CABE_OP_MASK_SET_BITS, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h1101);
    opnd(8'h8F, 8'h00, 8'hF0, 8'h08);
    go(`CABE_OP_AND_CONST, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h8004);
    opnd(8'h01, 8'h02, 8'h00, 8'h00);
    go(`CABE_OP_OR, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h0300);
    opnd(8'hFF, 8'h00, 8'h0F, 8'h01);
    go(`CABE_OP_MASK_CLEAR_BITS, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'hF005);
    opnd(8'h7F, 8'h00, 8'h00, 8'h01);
    go(`CABE_OP_INC, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h800D);
    opnd(8'h80, 8'h00, 8'h00, 8'h01);
    go(`CABE_OP_DEC, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h7F09);
    go(`CABE_OP_TEST, 4'h1);
    chk({7'h00, o_result_we_q, o_sreg_q}, 16'h0005);
    opnd(8'h55, 8'h00, 8'h00, 8'h01);
    go(`CABE_OP_CLEAR_REG, 4'h1);
    chk({o_result_q, o_sreg_q}, 16'h0003);
    go(`CABE_OP_SET_REG, 4'h1);
    chk({o_result_q, 6'h00, o_result_we_q, o_sreg_we_q}, 16'hFF02);
    $display("logic test done");
  endtask
  task t_word;
    i_rd_high = 8'h7F;
    opnd(8'hFF, 8'h00, 8'h01, 8'h00);
    go(`CABE_OP_WORD_IMMEDIATE_ADD, 4'h2);
    chk({o_result_high_q, o_result_q}, 16'h8000);
    chk({o_word_we_q, o_result_we_q, o_sreg_q}, 16'h030C);
    i_rd_high = 8'h00;
    opnd(8'h00, 8'h00, 8'h01, 8'h00);
    go(`CABE_OP_WORD_IMMEDIATE_SUBTRACT, 4'h2);
    chk({o_result_high_q, o_result_q}, 16'hFFFF);
    chk(o_sreg_q, 16'h0015);
    $display("word test done");
  endtask
  task t_flow;
    i_pc = 16'h0100;
    i_offset = 12'hFFE;
    go(`CABE_OP_RELATIVE_JUMP, 4'h2);
    chk(o_pc_q, 16'h00FF);
    i_z_ptr = 16'h1234;
    go(`CABE_OP_POINTER_JUMP, 4'h2);
    chk({o_pc_we_q, o_sreg_we_q, o_pc_q[13:0]}, 16'h9234);
    i_pc = 16'h0200;
    i_offset = 12'h005;
    go(`CABE_OP_RELATIVE_CALL, 4'h3);
    chk(o_pc_q, 16'h0206);
    chk(o_return_addr_q, 16'h0201);
    go(`CABE_OP_POINTER_CALL, 4'h3);
    chk({o_push_q, o_pc_we_q, o_pc_q[13:0]}, 16'hD234);
    chk(o_return_addr_q, 16'h0201);
    $display("flow test done");
  endtask
  task t_cmp;
    opnd(8'h10, 8'h20, 8'h00, 8'h00);
    go(`CABE_OP_COMPARE, 4'h1);
    chk({7'h00, o_result_we_q, o_sreg_q}, 16'h0005);
    opnd(8'h20, 8'h1F, 8'h00, 8'h03);
    go(`CABE_OP_COMPARE_CARRY, 4'h1);
    chk(o_sreg_q, 16'h0022);
    opnd(8'h05, 8'h00, 8'h05, 8'h00);
    go(`CABE_OP_COMPARE_CONST, 4'h1);
    chk(o_sreg_q, 16'h0002);
    i_pc = 16'h0300;
    i_next_two_word = 1'b1;
    opnd(8'h33, 8'h33, 8'h00, 8'h00);
    go(`CABE_OP_COMPARE_SKIP_EQUAL, 4'h3);
    chk({o_pc_we_q, o_sreg_we_q, o_pc_q[13:0]}, 16'h8303);
    i_rr = 8'h34;
    go(`CABE_OP_COMPARE_SKIP_EQUAL, 4'h1);
    chk(o_pc_we_q, 16'h0000);
    $display("compare test done");
  endtask
  task t_skip;
    i_next_two_word = 1'b0;
    i_bit_sel = 3'h3;
    i_rr = 8'h08;
    go(`CABE_OP_SKIP_REG_BIT_SET, 4'h2);
    chk({o_pc_we_q, o_pc_q[14:0]}, 16'h8302);
    go(`CABE_OP_SKIP_REG_BIT_CLEAR, 4'h1);
    chk(o_pc_we_q, 16'h0000);
    i_io_reg = 8'hF7;
    go(`CABE_OP_SKIP_IO_BIT_CLEAR, 4'h2);
    chk({o_pc_we_q, o_pc_q[14:0]}, 16'h8302);
    go(`CABE_OP_SKIP_IO_BIT_SET, 4'h1);
    chk(o_pc_we_q, 16'h0000);
    i_io_reg = 8'h08;
    i_next_two_word = 1'b1;
    go(`CABE_OP_SKIP_IO_BIT_SET, 4'h3);
    chk(o_pc_q, 16'h0303);
    $display("skip test done");
  endtask
  task t_branch;
    i_sreg = 8'h02;
    i_bit_sel = 3'h1;
    i_pc = 16'h0100;
    i_offset = 12'h010;
    go(`CABE_OP_BRANCH_FLAG_SET, 4'h2);
    chk({o_pc_we_q, o_pc_q[14:0]}, 16'h8111);
    go(`CABE_OP_BRANCH_FLAG_CLEAR, 4'h1);
    chk(o_pc_we_q, 16'h0000);
    $display("branch test done");
  endtask
  // Start held high through a call: the later add must leave no trace
  task t_refuse;
    i_pc = 16'h0400;
    i_offset = 12'h000;
    @(negedge i_clock);
    i_op = `CABE_OP_RELATIVE_CALL;
    i_start = 1'b1;
    @(negedge i_clock);
    i_op = `CABE_OP_ADD;
    chk(o_busy_q, 16'h0001);
    repeat (2) @(negedge i_clock);
    chk({o_done_q, o_push_q, o_pc_q[13:0]}, 16'hC401);
    i_start = 1'b0;
    @(negedge i_clock);
    chk(o_done_q, 16'h0000);
    $display("refusal test done");
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // Cut a hang short
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      close_out();
    end
  end
  initial
  begin
    i_reset_n = 1'b0;
    i_start = 1'b0;
    i_op = 6'h00;
    i_rd_high = 8'h00;
    i_bit_sel = 3'h0;
    i_io_reg = 8'h00;
    i_pc = 16'h0000;
    i_z_ptr = 16'h0000;
    i_offset = 12'h000;
    i_next_two_word = 1'b0;
    opnd(8'h00, 8'h00, 8'h00, 8'h00);
    repeat (3) @(negedge i_clock);
    i_reset_n = 1'b1;
    t_arith();
    t_logic();
    t_word();
    t_flow();
    t_cmp();
    t_skip();
    t_branch();
    t_refuse();
    close_out();
  end
endmodule // cpu_alu_branch_exec_bench
`default_nettype wire
